// ---- rtl/risc16_cpu_core.sv ----
// Notes on behaviour
// RQ1 - Sixteen-bit datapath, register-centred instruction set
// RQ2 - Seven source and four destination addressing modes
// RQ3 - Sixteen registers addressed directly by instructions
// RQ4 - Register to register execute takes one cycle
// RQ5 - R0 PC, R1 SP, R2 status, R3 constants
// RQ6 - 51 instructions, three formats, dual writes destination
// RQ7 - Word or byte variant chosen by encoding
// RQ8 - Call pushes PC, then loads operand
// RQ9 - Relative jumps; zero-clear jump needs Z clear
// RQ10 - Peripherals reached as memory over shared buses
// RQ11 - Untaken jump keeps sequential PC and status
`timescale 1ns/1ps
`default_nettype none

module risc16_cpu_core #(
    parameter logic [15:0] RESET_PC = risc16_pkg::RESET_PC_DEFAULT
) (
    input wire logic clock,
    input wire logic srst,
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic mem_byte,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    output logic [15:0] pc_value,
    output logic [15:0] sr_value
);
    import risc16_pkg::*;

    // Registered state and its next value
    core_t core_reg;
    core_t core_next;

    // Decode helpers from the held instruction
    logic single;
    logic bw;
    logic dmem;
    logic [1:0] as_f;
    logic [3:0] sreg;
    logic [3:0] dreg;
    logic [15:0] msk;
    // Register file ports
    logic [15:0] rdir;
    logic [3:0] ra;
    logic [3:0] rb;
    logic [15:0] rf_a;
    logic [15:0] rf_b;
    logic rf_we;
    logic [3:0] rf_wa;
    logic [15:0] rf_wd;
    // Operand values after role overrides
    logic [15:0] opa;
    logic [15:0] opb;
    // Execute scratch
    logic src_done;
    logic wb;
    logic flg;
    logic fetch_now;
    logic c;
    logic v;
    logic cin;
    logic [15:0] sv;
    logic [15:0] dv;
    logic [15:0] s;
    logic [15:0] t;
    logic [15:0] res;
    logic [15:0] npc;
    logic [15:0] a16;
    logic [16:0] sum;

    assign single = is_single(core_reg.ir);
    // Byte select bit of both operand formats
    // RQ7 byte/word select
    assign bw = core_reg.ir[6];
    assign as_f = core_reg.ir[5:4];
    assign sreg = single ? core_reg.ir[3:0] : core_reg.ir[11:8];
    assign dreg = core_reg.ir[3:0];
    assign dmem = single ? (as_f != 2'h0) : core_reg.ir[7];
    assign msk = bw ? 16'h00FF : 16'hFFFF;

    // Read addresses follow the word arriving during decode
    // RQ3 direct register addressing
    assign rdir = (core_reg.st == st_decode) ? mem_rdata : core_reg.ir;
    assign ra = is_single(rdir) ? rdir[3:0] : rdir[11:8];
    assign rb = is_single(rdir) ? REG_SP : rdir[3:0];

    reg_bank #(
        .WIDTH(WORD_W),
        .DEPTH(REG_COUNT)
    ) u_bank (
        .clock(clock),
        .rd_a_addr(ra),
        .rd_b_addr(rb),
        .rd_a_data(rf_a),
        .rd_b_data(rf_b),
        .wr_en(rf_we),
        .wr_addr(rf_wa),
        .wr_data(rf_wd)
    );

    // Source value: PC and status live in the core, R3 is constant
    // RQ5 fixed register roles
    always_comb begin
        case (sreg)
            REG_PC: opa = core_reg.pc;
            REG_SR: begin
                case (as_f)
                    2'h0: opa = core_reg.sr;
                    2'h2: opa = CG_FOUR;
                    2'h3: opa = CG_EIGHT;
                    default: opa = 16'h0000;
                endcase
            end
            REG_CG: begin
                case (as_f)
                    2'h1: opa = CG_ONE;
                    2'h2: opa = CG_TWO;
                    2'h3: opa = CG_ALL;
                    default: opa = 16'h0000;
                endcase
            end
            default: opa = rf_a;
        endcase
    end

    // Destination register value with the same overrides
    always_comb begin
        case (rb)
            REG_PC: opb = core_reg.pc;
            REG_SR: opb = core_reg.sr;
            REG_CG: opb = 16'h0000;
            default: opb = rf_b;
        endcase
    end

    // Sequencer and datapath
    always_comb begin
        core_next = core_reg;
        mem_addr = 16'h0000;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_byte = 1'b0;
        mem_wdata = 16'h0000;
        rf_we = 1'b0;
        rf_wa = dreg;
        rf_wd = 16'h0000;
        src_done = 1'b0;
        wb = 1'b0;
        flg = 1'b0;
        fetch_now = 1'b0;
        c = core_reg.sr[SR_C];
        v = 1'b0;
        cin = 1'b0;
        sv = core_reg.src;
        s = core_reg.src & msk;
        dv = core_reg.dval;
        t = 16'h0000;
        res = 16'h0000;
        npc = core_reg.pc;
        a16 = 16'h0000;
        sum = 17'h00000;
        case (core_reg.st)
            // Instruction word request
            // RQ10 memory bus access
            st_fetch: begin
                mem_rd = 1'b1;
                mem_addr = core_reg.pc;
                core_next.pc = core_reg.pc + 16'h0002;
                core_next.st = st_decode;
            end
            // Latch the word; jumps finish here
            st_decode: begin
                core_next.ir = mem_rdata;
                core_next.st = st_fetch;
                if (is_jump(mem_rdata)) begin
                    // RQ9 condition test
                    // RQ11 untaken keeps PC, SR
                    if (jump_taken(mem_rdata[12:10], core_reg.sr))
                        core_next.pc = core_reg.pc +
                            {{5{mem_rdata[9]}}, mem_rdata[9:0], 1'b0};
                end else if (is_single(mem_rdata) ||
                             mem_rdata[15:14] != 2'h0) begin
                    core_next.st = st_oper;
                end
            end
            // Source addressing mode
            // RQ2 source modes
            st_oper: begin
                if (as_f == 2'h0 || sreg == REG_CG ||
                    (sreg == REG_SR && as_f[1])) begin
                    src_done = 1'b1;
                    sv = opa;
                end else if (as_f == 2'h1) begin
                    // Indexed, symbolic or absolute: fetch the offset
                    mem_rd = 1'b1;
                    mem_addr = core_reg.pc;
                    core_next.pc = core_reg.pc + 16'h0002;
                    core_next.xbase = (sreg == REG_PC) ? core_reg.pc :
                        (sreg == REG_SR) ? 16'h0000 : rf_a;
                    core_next.st = st_src_x;
                end else begin
                    // Indirect; immediate is indirect autoincrement on PC
                    mem_rd = 1'b1;
                    mem_addr = opa;
                    core_next.dad = opa;
                    core_next.rd_hi = opa[0];
                    core_next.st = st_src_m;
                    if (as_f == 2'h3) begin
                        // SP and PC always step by a whole word
                        a16 = (bw && sreg != REG_SP) ? 16'h0001 : 16'h0002;
                        if (sreg == REG_PC) begin
                            core_next.pc = core_reg.pc + 16'h0002;
                        end else begin
                            rf_we = 1'b1;
                            rf_wa = sreg;
                            rf_wd = opa + a16;
                        end
                    end
                end
            end
            // Offset arrived, read the operand
            st_src_x: begin
                a16 = mem_rdata + core_reg.xbase;
                mem_rd = 1'b1;
                mem_addr = a16;
                core_next.dad = a16;
                core_next.rd_hi = a16[0];
                core_next.st = st_src_m;
            end
            st_src_m: begin
                src_done = 1'b1;
                sv = rd_val(mem_rdata, core_reg.rd_hi, bw);
            end
            // Destination offset arrived; a move needs no old value
            st_dst_x: begin
                a16 = mem_rdata + core_reg.xbase;
                core_next.dad = a16;
                core_next.rd_hi = a16[0];
                core_next.st = st_exec;
                if (core_reg.ir[15:12] != OP_MOV) begin
                    mem_rd = 1'b1;
                    mem_addr = a16;
                    core_next.st = st_dst_m;
                end
            end
            st_dst_m: begin
                core_next.dval = rd_val(mem_rdata, core_reg.rd_hi, bw);
                core_next.st = st_exec;
            end
            // One cycle of work, then write back
            st_exec: begin
                dv = dmem ? core_reg.dval : (single ? core_reg.src : opb);
                dv = dv & msk;
                core_next.st = st_fetch;
                if (single) begin
                    case (core_reg.ir[9:7])
                        // RQ8 push PC, jump
                        SOP_PUSH, SOP_CALL: begin
                            a16 = rf_b - 16'h0002;
                            rf_we = 1'b1;
                            rf_wa = REG_SP;
                            rf_wd = a16;
                            mem_wr = 1'b1;
                            mem_addr = a16;
                            if (core_reg.ir[9:7] == SOP_CALL) begin
                                mem_wdata = core_reg.pc;
                                core_next.pc = core_reg.src;
                            end else begin
                                mem_byte = bw;
                                mem_wdata = bw ? {2{core_reg.src[7:0]}} :
                                    core_reg.src;
                            end
                        end
                        // Pop status, then PC
                        SOP_RETI: begin
                            mem_rd = 1'b1;
                            mem_addr = rf_b;
                            a16 = rf_b + 16'h0002;
                            rf_we = 1'b1;
                            rf_wa = REG_SP;
                            rf_wd = a16;
                            core_next.dad = a16;
                            core_next.st = st_pop_sr;
                        end
                        SOP_RRC, SOP_RRA: begin
                            res = dv >> 1;
                            if (bw)
                                res[7] = (core_reg.ir[9:7] == SOP_RRC) ?
                                    c : dv[7];
                            else
                                res[15] = (core_reg.ir[9:7] == SOP_RRC) ?
                                    c : dv[15];
                            c = dv[0];
                            flg = 1'b1;
                            wb = 1'b1;
                        end
                        SOP_SWPB: begin
                            res = {core_reg.src[7:0], core_reg.src[15:8]};
                            wb = 1'b1;
                        end
                        SOP_SXT: begin
                            res = {{8{core_reg.src[7]}}, core_reg.src[7:0]};
                            c = res != 16'h0000;
                            flg = 1'b1;
                            wb = 1'b1;
                        end
                        default: core_next.st = st_fetch;
                    endcase
                end else begin
                    // RQ6 dual result to destination
                    // RQ1 register datapath
                    case (core_reg.ir[15:12])
                        OP_MOV: begin
                            res = s;
                            wb = 1'b1;
                        end
                        OP_ADD, OP_ADDC, OP_SUBC, OP_SUB, OP_CMP: begin
                            t = (core_reg.ir[15:12] >= OP_SUBC) ?
                                (~s & msk) : s;
                            cin = (core_reg.ir[15:12] == OP_ADD) ? 1'b0 :
                                (core_reg.ir[15:12] == OP_ADDC ||
                                 core_reg.ir[15:12] == OP_SUBC) ? c : 1'b1;
                            sum = {1'b0, dv} + {1'b0, t} + {16'h0000, cin};
                            res = sum[15:0] & msk;
                            c = bw ? sum[8] : sum[16];
                            v = (msb(dv, bw) == msb(t, bw)) &&
                                (msb(res, bw) != msb(dv, bw));
                            flg = 1'b1;
                            wb = core_reg.ir[15:12] != OP_CMP;
                        end
                        OP_DADD: begin
                            sum = bcd_add(dv, s, c, bw);
                            res = sum[15:0];
                            c = sum[16];
                            flg = 1'b1;
                            wb = 1'b1;
                        end
                        OP_BIT, OP_AND: begin
                            res = s & dv;
                            c = res != 16'h0000;
                            flg = 1'b1;
                            wb = core_reg.ir[15:12] == OP_AND;
                        end
                        OP_XOR: begin
                            res = s ^ dv;
                            c = res != 16'h0000;
                            v = msb(s, bw) & msb(dv, bw);
                            flg = 1'b1;
                            wb = 1'b1;
                        end
                        OP_BIC: begin
                            res = dv & ~s;
                            wb = 1'b1;
                        end
                        default: begin
                            res = dv | s;
                            wb = 1'b1;
                        end
                    endcase
                end
                // Flags first so a write to the status register wins
                if (flg) begin
                    core_next.sr[SR_C] = c;
                    core_next.sr[SR_Z] = res == 16'h0000;
                    core_next.sr[SR_N] = msb(res, bw);
                    core_next.sr[SR_V] = v;
                end
                fetch_now = !(single && core_reg.ir[9] &&
                              core_reg.ir[9:7] != SOP_SXT + 3'h4);
                if (wb && dmem) begin
                    fetch_now = 1'b0;
                    mem_wr = 1'b1;
                    mem_addr = core_reg.dad;
                    mem_byte = bw;
                    mem_wdata = bw ? {2{res[7:0]}} : res;
                end else if (wb) begin
                    case (dreg)
                        REG_PC: npc = res;
                        REG_SR: core_next.sr = res;
                        REG_CG: core_next.sr = core_next.sr;
                        default: begin
                            rf_we = 1'b1;
                            rf_wa = dreg;
                            rf_wd = res;
                        end
                    endcase
                end
            end
            st_pop_sr: begin
                core_next.sr = mem_rdata;
                mem_rd = 1'b1;
                mem_addr = core_reg.dad;
                rf_we = 1'b1;
                rf_wa = REG_SP;
                rf_wd = core_reg.dad + 16'h0002;
                core_next.st = st_pop_pc;
            end
            st_pop_pc: begin
                core_next.pc = mem_rdata;
                core_next.st = st_fetch;
            end
            default: core_next.st = st_fetch;
        endcase
        // Source in hand: go on to the destination
        // RQ2 destination modes
        if (src_done) begin
            core_next.src = sv;
            core_next.st = st_exec;
            if (!single && core_reg.ir[7]) begin
                mem_rd = 1'b1;
                mem_addr = core_reg.pc;
                core_next.pc = core_reg.pc + 16'h0002;
                core_next.xbase = (dreg == REG_PC) ? core_reg.pc :
                    (dreg == REG_SR) ? 16'h0000 : rf_b;
                core_next.st = st_dst_x;
            end
        end
        // Next fetch overlaps a register write back
        // RQ4 single execute cycle
        if (fetch_now) begin
            mem_rd = 1'b1;
            mem_addr = npc;
            core_next.pc = npc + 16'h0002;
            core_next.st = st_decode;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            core_reg <= '0;
            core_reg.pc <= RESET_PC;
        end else begin
            core_reg <= core_next;
        end
    end

    // Visible state
    assign pc_value = core_reg.pc;
    assign sr_value = core_reg.sr;

endmodule : risc16_cpu_core

`default_nettype wire

// ---- rtl/risc16_pkg.sv ----
package risc16_pkg;

    // Datapath and register file shape
    localparam int WORD_W = 16;
    localparam int REG_COUNT = 16;
    localparam logic [15:0] RESET_PC_DEFAULT = 16'hC000;

    // Registers with fixed roles
    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_SP = 4'h1;
    localparam logic [3:0] REG_SR = 4'h2;
    localparam logic [3:0] REG_CG = 4'h3;

    // Status register bit positions
    localparam int SR_C = 0;
    localparam int SR_Z = 1;
    localparam int SR_N = 2;
    localparam int SR_V = 8;

    // Constant generator values
    localparam logic [15:0] CG_FOUR = 16'h0004;
    localparam logic [15:0] CG_EIGHT = 16'h0008;
    localparam logic [15:0] CG_ONE = 16'h0001;
    localparam logic [15:0] CG_TWO = 16'h0002;
    localparam logic [15:0] CG_ALL = 16'hFFFF;

    // Dual operand opcodes, bits 15..12
    localparam logic [3:0] OP_MOV = 4'h4;
    localparam logic [3:0] OP_ADD = 4'h5;
    localparam logic [3:0] OP_ADDC = 4'h6;
    localparam logic [3:0] OP_SUBC = 4'h7;
    localparam logic [3:0] OP_SUB = 4'h8;
    localparam logic [3:0] OP_CMP = 4'h9;
    localparam logic [3:0] OP_DADD = 4'hA;
    localparam logic [3:0] OP_BIT = 4'hB;
    localparam logic [3:0] OP_BIC = 4'hC;
    localparam logic [3:0] OP_BIS = 4'hD;
    localparam logic [3:0] OP_XOR = 4'hE;
    localparam logic [3:0] OP_AND = 4'hF;

    // Single operand opcodes, bits 9..7
    localparam logic [2:0] SOP_RRC = 3'h0;
    localparam logic [2:0] SOP_SWPB = 3'h1;
    localparam logic [2:0] SOP_RRA = 3'h2;
    localparam logic [2:0] SOP_SXT = 3'h3;
    localparam logic [2:0] SOP_PUSH = 3'h4;
    localparam logic [2:0] SOP_CALL = 3'h5;
    localparam logic [2:0] SOP_RETI = 3'h6;

    // Jump conditions, bits 12..10
    localparam logic [2:0] JC_ZERO_CLEAR = 3'h0;
    localparam logic [2:0] JC_ZERO_SET = 3'h1;
    localparam logic [2:0] JC_CARRY_CLEAR = 3'h2;
    localparam logic [2:0] JC_CARRY_SET = 3'h3;
    localparam logic [2:0] JC_NEG = 3'h4;
    localparam logic [2:0] JC_GE = 3'h5;
    localparam logic [2:0] JC_LT = 3'h6;

    // Sequencer states, Gray steps along the usual path
    typedef enum logic [3:0] {
        st_fetch = 4'h0,
        st_decode = 4'h1,
        st_oper = 4'h3,
        st_src_x = 4'h2,
        st_src_m = 4'h6,
        st_dst_x = 4'h7,
        st_dst_m = 4'h5,
        st_exec = 4'h4,
        st_pop_sr = 4'hC,
        st_pop_pc = 4'hD
    } state_t;

    // Whole state of the core
    typedef struct packed {
        state_t st;
        logic [15:0] ir;
        logic [15:0] pc;
        logic [15:0] sr;
        logic [15:0] src;
        logic [15:0] dval;
        logic [15:0] dad;
        logic [15:0] xbase;
        logic rd_hi;
    } core_t;

    function automatic logic is_single(input logic [15:0] w);
        return w[15:10] == 6'h04;
    endfunction : is_single

    function automatic logic is_jump(input logic [15:0] w);
        return w[15:13] == 3'h1;
    endfunction : is_jump

    function automatic logic msb(input logic [15:0] w, input logic bw);
        return bw ? w[7] : w[15];
    endfunction : msb

    // Byte reads pick the lane named by address bit zero
    function automatic logic [15:0] rd_val(input logic [15:0] d,
                                           input logic hi, input logic bw);
        if (!bw)
            return d;
        return {8'h00, hi ? d[15:8] : d[7:0]};
    endfunction : rd_val

    function automatic logic jump_taken(input logic [2:0] cond,
                                        input logic [15:0] sr);
        case (cond)
            JC_ZERO_CLEAR: return !sr[SR_Z];
            JC_ZERO_SET: return sr[SR_Z];
            JC_CARRY_CLEAR: return !sr[SR_C];
            JC_CARRY_SET: return sr[SR_C];
            JC_NEG: return sr[SR_N];
            JC_GE: return !(sr[SR_N] ^ sr[SR_V]);
            JC_LT: return sr[SR_N] ^ sr[SR_V];
            default: return 1'b1;
        endcase
    endfunction : jump_taken

    // Decimal add, carry out in bit 16
    function automatic logic [16:0] bcd_add(input logic [15:0] a,
                                            input logic [15:0] b,
                                            input logic cin, input logic bw);
        logic [4:0] s;
        logic cy;
        logic c8;
        logic [15:0] r;
        cy = cin;
        c8 = 1'b0;
        r = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            s = {1'b0, a[i*4+:4]} + {1'b0, b[i*4+:4]} + {4'h0, cy};
            if (s > 5'h09)
                s = s + 5'h06;
            r[i*4+:4] = s[3:0];
            cy = s[4];
            if (i == 1)
                c8 = cy;
        end
        return bw ? {c8, 8'h00, r[7:0]} : {cy, r};
    endfunction : bcd_add

endpackage : risc16_pkg

// ---- rtl/reg_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two read ports, one write port; read data is registered
module reg_bank #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clock,
    input wire logic [AW-1:0] rd_a_addr,
    input wire logic [AW-1:0] rd_b_addr,
    output logic [WIDTH-1:0] rd_a_data,
    output logic [WIDTH-1:0] rd_b_data,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data
);

    // Storage, no reset: software sets what it uses
    logic [WIDTH-1:0] mem [DEPTH];

    // Refuse shapes the addressing cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("reg_bank depth must be a power of two");
    end

    // Read before write: a same-cycle write shows a cycle later
    always_ff @(posedge clock) begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_a_data <= mem[rd_a_addr];
        rd_b_data <= mem[rd_b_addr];
    end

endmodule : reg_bank

`default_nettype wire

// ---- tb/risc16_cpu_core_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module risc16_cpu_core_properties #(
    parameter logic [15:0] RESET_PC = risc16_pkg::RESET_PC_DEFAULT
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_byte,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic [15:0] pc_value,
    input wire logic [15:0] sr_value
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // First cycle out of reset, and a write followed by its fetch
    sequence s_boot; $fell(srst); endsequence
    sequence s_wr_fetch; mem_wr ##1 mem_rd; endsequence
    property p_boot_fetch; s_boot |-> mem_rd && mem_addr == RESET_PC;
    endproperty
    property p_boot_regs; s_boot |-> pc_value == RESET_PC && !sr_value;
    endproperty
    property p_boot_idle; s_boot |=> !mem_rd && !mem_wr; endproperty
    property p_one_access; !(mem_rd && mem_wr); endproperty
    property p_wr_fetch; mem_wr |=> mem_rd && !mem_wr; endproperty
    property p_fetch_at_pc; s_wr_fetch |-> mem_addr == pc_value; endproperty
    property p_byte_lanes;
        mem_wr && mem_byte |-> mem_wdata[15:8] == mem_wdata[7:0];
    endproperty
    property p_pc_even; pc_value[0] == 1'b0; endproperty
    a_boot_fetch: assert property (p_boot_fetch) else $error("boot");
    a_boot_regs: assert property (p_boot_regs) else $error("regs");
    a_boot_idle: assert property (p_boot_idle) else $error("idle");
    a_one_access: assert property (p_one_access) else $error("two");
    a_wr_fetch: assert property (p_wr_fetch) else $error("wrf");
    a_fetch_at_pc: assert property (p_fetch_at_pc) else $error("pc");
    a_byte_lanes: assert property (p_byte_lanes) else $error("lane");
    a_pc_even: assert property (p_pc_even) else $error("odd");
endmodule : risc16_cpu_core_properties
bind risc16_cpu_core risc16_cpu_core_properties #(.RESET_PC(RESET_PC))
    u_props (.clock(clock), .srst(srst), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .pc_value(pc_value), .sr_value(sr_value));
`default_nettype wire

// ---- tb/bus_memory.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_memory (
    input wire logic clock,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic mem_byte,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata
);
    // 4 KB; higher addresses alias, fine for short programs
    logic [15:0] mem [0:2047];
    always @(posedge clock) begin
        // Idle cycles toggle the data so a stale word matches only after an even number of them
        mem_rdata <= mem_rd ? mem[mem_addr[11:1]] : ~mem_rdata;
        if (mem_wr && !mem_byte)
            mem[mem_addr[11:1]] <= mem_wdata;
        if (mem_wr && mem_byte && mem_addr[0])
            mem[mem_addr[11:1]][15:8] <= mem_wdata[15:8];
        if (mem_wr && mem_byte && !mem_addr[0])
            mem[mem_addr[11:1]][7:0] <= mem_wdata[7:0];
    end
endmodule : bus_memory
`default_nettype wire

// ---- tb/tb_risc16_cpu_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h", $time, g); end end
module tb_risc16_cpu_core;
    import risc16_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, pc_value, sr_value;
    logic mem_rd, mem_wr, mem_byte;
    int fail_count = 0;
    int compares = 0;
    logic [31:0] seed = 32'd97813;
    logic [15:0] a, b;
    logic [15:0] prog [0:23];
    always #25 clock = ~clock;
    risc16_cpu_core #(.RESET_PC(16'h0100)) u_dut (.clock(clock),
        .srst(srst), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_byte(mem_byte), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .pc_value(pc_value), .sr_value(sr_value));
    bus_memory u_mem (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_byte(mem_byte), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic complete_run();
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    // Watchdog, well past three runs of about 220 cycles
    initial begin
        repeat (3000) @(posedge clock);
        fail_count++;
        complete_run();
    end
    // Store, byte store, untaken and taken jump, call, each run
    initial begin
        prog = '{16'h4031, 16'h0300, 16'h4034, 16'h0000, 16'h4035, 16'h0000,
            16'h5405, 16'h4582, 16'h0200, 16'h44C2, 16'h0203, 16'h9404,
            16'h2001, 16'h4406, 16'h4682, 16'h0204, 16'h9405, 16'h2001,
            16'h4506, 16'h4682, 16'h0206, 16'h12B0, 16'h0140, 16'h3FFF};
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            a = (i == 0) ? 16'hFFFF : seed[15:0];
            seed = lfsr(seed);
            b = seed[15:0] | 16'h0001;
            prog[3] = a;
            prog[5] = b;
            @(posedge clock);
            srst <= 1'b1;
            for (int k = 0; k < 24; k++) u_mem.mem[128 + k] = prog[k];
            for (int k = 256; k < 261; k++) u_mem.mem[k] = 16'h0000;
            u_mem.mem[383] = 16'h0000;
            u_mem.mem[160] = 16'h4482;
            u_mem.mem[161] = 16'h0208;
            u_mem.mem[162] = 16'h3FFF;
            repeat (20) @(posedge clock);
            `CHK(pc_value, 16'h0100)
            srst <= 1'b0;
            repeat (200) @(posedge clock);
            `CHK(u_mem.mem[256], a + b)
            `CHK(u_mem.mem[257], {a[7:0], 8'h00})
            `CHK(u_mem.mem[258], a)
            `CHK(u_mem.mem[259], a)
            `CHK(u_mem.mem[383], 16'h012E)
            `CHK(u_mem.mem[260], a)
            `CHK(sr_value[SR_Z], 1'b0)
        end
        complete_run();
    end
endmodule : tb_risc16_cpu_core
`default_nettype wire
